// ===== hdl/spl_op_if.sv
// start and completion signals between sequencer and operation timer
`timescale 1ns/1ps
interface spl_op_if;
  logic start;
  logic [spl_pkg::LEN_W-1:0] len;
  logic busy;
  logic done;
  modport ctl(output start, output len, input busy, input done);
  modport tmr(input start, input len, output busy, output done);
endinterface

// ===== hdl/spl_op_timer.sv
// busy timer standing in for nonvolatile program and erase time
`timescale 1ns/1ps
module spl_op_timer (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic abort_i,
  spl_op_if.tmr op
);
  logic [spl_pkg::LEN_W-1:0] cnt_r;
  logic done_r;

  assign op.busy = (cnt_r != '0);
  assign op.done = done_r;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (abort_i) begin
      cnt_r <= '0;
    end else if (op.start && cnt_r == '0) begin
      cnt_r <= op.len;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // done marks the last busy cycle so the result lands with wip falling
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= !abort_i && cnt_r == 12'h002;
    end
  end

  a_len_min: assert property (@(posedge core_clk_i) disable iff (rst_i)
    op.start && !op.busy && !abort_i |=> op.busy [*2])
    else $error("timer busy shorter than two cycles");
endmodule

// ===== hdl/spl_pkg.sv
// shared constants and types for the sector protection logic
package spl_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NSECT = 256;
  localparam int SA_W = 8;
  localparam int PWD_W = 64;
  localparam int LEN_W = 12;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_SECT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_PWD_LO = 8'h0c;
  localparam logic [7:0] OFS_PWD_HI = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_LOCKRD = 8'h18;
  localparam logic [7:0] OFS_RANGE = 8'h1c;
  // ****************************************************************
  // command codes, written to the low nibble of the command register
  // ****************************************************************
  localparam logic [3:0] OP_NV_PROG = 4'h1;
  localparam logic [3:0] OP_NV_ERASE = 4'h2;
  localparam logic [3:0] OP_VOL_WRITE = 4'h3;
  localparam logic [3:0] OP_GATE_CLR = 4'h4;
  localparam logic [3:0] OP_PWD_UNLOCK = 4'h5;
  localparam logic [3:0] OP_MODE_PROG = 4'h6;
  localparam logic [3:0] OP_PWD_PROG = 4'h7;
  localparam logic [3:0] OP_CLR_STAT = 4'h8;
  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam int ST_WIP = 0;
  localparam int ST_PERR = 1;
  localparam int ST_GATE = 2;
  localparam int ST_PWMODE = 3;
  localparam int ST_MODE_LO = 4;
  localparam int RNG_BOT = 3;
  localparam int MODE_LO = 1;
  localparam logic [1:0] MODE_NONE = 2'h3;
  localparam logic [1:0] MODE_PERSIST = 2'h2;
  localparam logic [1:0] MODE_PASSWD = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL = 2'h0;
  localparam logic [7:0] LOCK_BYTE_PROT = 8'h00;
  localparam logic [7:0] LOCK_BYTE_OPEN = 8'hff;
  localparam logic [PWD_W-1:0] PWD_RST = {PWD_W{1'b1}};
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int UNLOCK_GAP_US = 100;
  localparam int UNLOCK_GAP_CYC = UNLOCK_GAP_US * CLK_MHZ;
  localparam logic [LEN_W-1:0] PROG_CYC = 12'h100;
  localparam logic [LEN_W-1:0] ERASE_CYC = 12'h800;
  // ****************************************************************
  // command sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    SPL_IDLE = 3'b001,
    SPL_BUSY = 3'b010,
    SPL_FAIL = 3'b100
  } spl_state_t;
endpackage

// ===== hdl/spl_top.sv
// per-sector lock logic with gate bit and guard mode register
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - sector protected if range guard or per-sector scheme protects it
// - sector protected when its nonvolatile or volatile lock bit is 0
// - gate bit 0 blocks program and erase of nonvolatile lock bits
// - persistent mode: gate set on hardware reset, never set by command
// - password mode: gate cleared on hardware reset, set on password match
// - gate-clear command clears the gate in either mode
// - password mode: only successful unlock sets the gate
// - mode bits 11 none, 10 persistent, 01 password, 00 fails
// - once a mode bit is programmed, mode register never changes
// - mode register program takes a program time with wip set
// - unprogrammed part powers up persistent with all sectors open
// - nonvolatile bits programmed singly to 0, erased all to 1
// - with gate 0, nonvolatile program or erase fails, bits unchanged
// - read returns nonvolatile lock state of addressed sector
// - status stays readable during nonvolatile program or erase
// - volatile write sets bit 0 or 1; matters only if nv bit is 1
// - volatile bits rewritable, open again after any reset
// - volatile bits writable regardless of gate; nv only with gate 1
// - device handles erase preprogramming and verify internally
// - bad password sets program error, keeps wip, gate stays 0
// - unlock accepted at most once per 100 us, valid skips delay
// - software reset leaves gate unchanged in persistent mode
// - volatile lock byte 00h protected, FFh unprotected
module spl_top #(
  parameter int UNLOCK_GAP_CYC = spl_pkg::UNLOCK_GAP_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic hw_rst_i,
  input wire logic sw_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [spl_pkg::SA_W-1:0] query_sect_i,
  output logic sect_protected_o,
  output logic write_in_progress_flag_o,
  output logic lock_gate_bit_o
);
  localparam int NS = spl_pkg::NSECT;
  localparam int SW = spl_pkg::SA_W;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic pready_r, pslverr_r, apb_wr, addr_ok;
  logic [31:0] prdata_r, rd_mux;

  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign prdata_o = prdata_r;
  assign apb_wr = psel_i && penable_i && pready_r && pwrite_i;
  assign addr_ok = paddr_i == spl_pkg::OFS_CMD ||
    paddr_i == spl_pkg::OFS_SECT || paddr_i == spl_pkg::OFS_DATA ||
    paddr_i == spl_pkg::OFS_PWD_LO || paddr_i == spl_pkg::OFS_PWD_HI ||
    paddr_i == spl_pkg::OFS_STAT || paddr_i == spl_pkg::OFS_LOCKRD ||
    paddr_i == spl_pkg::OFS_RANGE;

  // one wait state so read data comes from a flop
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (psel_i && penable_i && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= !addr_ok;
      prdata_r <= pwrite_i ? 32'h0 : rd_mux;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ****************************************************************
  // software visible registers
  // ****************************************************************
  logic [SW-1:0] sect_r;
  logic [7:0] data_r;
  logic [spl_pkg::PWD_W-1:0] cand_r;
  logic [3:0] rng_r;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sect_r <= '0;
      data_r <= '0;
      cand_r <= '0;
      rng_r <= '0;
    end else if (apb_wr) begin
      if (paddr_i == spl_pkg::OFS_SECT) sect_r <= pwdata_i[SW-1:0];
      if (paddr_i == spl_pkg::OFS_DATA) data_r <= pwdata_i[7:0];
      if (paddr_i == spl_pkg::OFS_PWD_LO) cand_r[31:0] <= pwdata_i;
      if (paddr_i == spl_pkg::OFS_PWD_HI) cand_r[63:32] <= pwdata_i;
      if (paddr_i == spl_pkg::OFS_RANGE) rng_r <= pwdata_i[3:0];
    end
  end

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  spl_pkg::spl_state_t state_r;
  spl_op_if op_bus ();
  logic [3:0] op_r, cmd;
  logic [SW-1:0] op_sect_r;
  logic cmd_go, idle, any_rst, perr_r, gate_r;
  logic [1:0] mode_r;
  logic [NS-1:0] nv_r, vol_r;
  logic [spl_pkg::PWD_W-1:0] pwd_r;
  logic pwd_mode, pwd_match, unlock_ok, unlock_bad;
  logic [13:0] gap_r;
  logic nv_denied, mode_denied, go_nv, go_mode, go_pwd;

  assign cmd_go = apb_wr && paddr_i == spl_pkg::OFS_CMD;
  assign cmd = pwdata_i[3:0];
  assign idle = (state_r == spl_pkg::SPL_IDLE);
  assign any_rst = hw_rst_i || sw_rst_i;
  assign pwd_mode = (mode_r == spl_pkg::MODE_PASSWD);
  assign pwd_match = (cand_r == pwd_r);
  // unlock is only meaningful in password mode and honours the gap
  assign unlock_ok = cmd_go && idle && cmd == spl_pkg::OP_PWD_UNLOCK &&
                     pwd_mode && gap_r == '0 && pwd_match;
  assign unlock_bad = cmd_go && idle && cmd == spl_pkg::OP_PWD_UNLOCK &&
                      pwd_mode && gap_r == '0 && !pwd_match;
  assign nv_denied = !gate_r;
  assign mode_denied = mode_r != spl_pkg::MODE_NONE ||
                       data_r[2:1] == spl_pkg::MODE_ILLEGAL;
  assign go_nv = cmd_go && idle && !any_rst && !nv_denied &&
                 (cmd == spl_pkg::OP_NV_PROG || cmd == spl_pkg::OP_NV_ERASE);
  assign go_mode = cmd_go && idle && !any_rst && !mode_denied &&
                   cmd == spl_pkg::OP_MODE_PROG;
  assign go_pwd = cmd_go && idle && !any_rst && !pwd_mode &&
                  cmd == spl_pkg::OP_PWD_PROG;

  assign op_bus.start = go_nv || go_mode || go_pwd;
  assign op_bus.len = (cmd == spl_pkg::OP_NV_ERASE) ?
                      spl_pkg::ERASE_CYC : spl_pkg::PROG_CYC;

  spl_op_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .abort_i(any_rst),
    .op(op_bus.tmr)
  );

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= spl_pkg::SPL_IDLE;
    end else if (any_rst) begin
      state_r <= spl_pkg::SPL_IDLE;
    end else begin
      case (state_r)
        spl_pkg::SPL_IDLE: begin
          if (op_bus.start) begin
            state_r <= spl_pkg::SPL_BUSY;
          end else if (unlock_bad) begin
            state_r <= spl_pkg::SPL_FAIL;
          end else if (cmd_go && cmd == spl_pkg::OP_MODE_PROG) begin
            state_r <= spl_pkg::SPL_FAIL;
          end else if (cmd_go && nv_denied &&
                       (cmd == spl_pkg::OP_NV_PROG ||
                        cmd == spl_pkg::OP_NV_ERASE)) begin
            state_r <= spl_pkg::SPL_FAIL;
          end
        end
        spl_pkg::SPL_BUSY: begin
          if (op_bus.done) state_r <= spl_pkg::SPL_IDLE;
        end
        spl_pkg::SPL_FAIL: begin
          if (cmd_go && cmd == spl_pkg::OP_CLR_STAT) begin
            state_r <= spl_pkg::SPL_IDLE;
          end
        end
        default: state_r <= spl_pkg::SPL_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_r <= '0;
      op_sect_r <= '0;
    end else if (op_bus.start) begin
      op_r <= cmd;
      op_sect_r <= sect_r;
    end
  end

  // error flag: a new failure in the clearing cycle wins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      perr_r <= 1'b0;
    end else if (any_rst) begin
      perr_r <= 1'b0;
    end else if (idle && cmd_go && !op_bus.start &&
                 (unlock_bad || cmd == spl_pkg::OP_MODE_PROG ||
                  ((cmd == spl_pkg::OP_NV_PROG ||
                    cmd == spl_pkg::OP_NV_ERASE) && nv_denied))) begin
      perr_r <= 1'b1;
    end else if (cmd_go && cmd == spl_pkg::OP_CLR_STAT) begin
      perr_r <= 1'b0;
    end
  end

  // ****************************************************************
  // unlock rate limiter
  // ****************************************************************
  // only a failed attempt arms the gap, so a valid password costs nothing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_r <= '0;
    end else if (unlock_bad) begin
      gap_r <= 14'(UNLOCK_GAP_CYC);
    end else if (gap_r != '0) begin
      gap_r <= gap_r - 1'b1;
    end
  end

  // ****************************************************************
  // lock gate and guard mode
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_r <= 1'b1;
    end else if (hw_rst_i) begin
      gate_r <= !pwd_mode;
    end else if (sw_rst_i) begin
      gate_r <= gate_r;
    end else if (cmd_go && idle && cmd == spl_pkg::OP_GATE_CLR) begin
      gate_r <= 1'b0;
    end else if (unlock_ok) begin
      gate_r <= 1'b1;
    end
  end

  // one-time bits: power-on value is the unprogrammed state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= spl_pkg::MODE_NONE;
      pwd_r <= spl_pkg::PWD_RST;
    end else if (op_bus.done && op_r == spl_pkg::OP_MODE_PROG) begin
      mode_r <= mode_r & data_r[spl_pkg::MODE_LO +: 2];
    end else if (op_bus.done && op_r == spl_pkg::OP_PWD_PROG) begin
      pwd_r <= pwd_r & cand_r;
    end
  end

  // ****************************************************************
  // per-sector lock bits
  // ****************************************************************
  // nv bits live in flops here; rst_i stands for first power-up only
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sect
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          nv_r[g] <= 1'b1;
        end else if (op_bus.done && op_r == spl_pkg::OP_NV_ERASE) begin
          nv_r[g] <= 1'b1;
        end else if (op_bus.done && op_r == spl_pkg::OP_NV_PROG &&
                     op_sect_r == SW'(g)) begin
          nv_r[g] <= 1'b0;
        end
      end
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          vol_r[g] <= 1'b1;
        end else if (any_rst) begin
          vol_r[g] <= 1'b1;
        end else if (cmd_go && cmd == spl_pkg::OP_VOL_WRITE &&
                     sect_r == SW'(g)) begin
          vol_r[g] <= (data_r == spl_pkg::LOCK_BYTE_OPEN);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // protection decision and read back
  // ****************************************************************
  logic [8:0] rng_cnt, q9;
  logic rng_hit;

  assign q9 = {1'b0, query_sect_i};
  assign rng_cnt = (rng_r[2:0] == 3'h0) ? 9'h000 :
                   (rng_r[2:0] == 3'h7) ? 9'h100 :
                   9'(9'h004 << (rng_r[2:0] - 3'h1));
  assign rng_hit = rng_r[spl_pkg::RNG_BOT] ? (q9 < rng_cnt) :
                   (q9 >= 9'(9'h100 - rng_cnt));
  assign sect_protected_o = rng_hit || !nv_r[query_sect_i] ||
                            !vol_r[query_sect_i];
  assign write_in_progress_flag_o = !idle;
  assign lock_gate_bit_o = gate_r;

  always_comb begin
    rd_mux = '0;
    case (paddr_i)
      spl_pkg::OFS_SECT: rd_mux = {24'h0, sect_r};
      spl_pkg::OFS_DATA: rd_mux = {24'h0, data_r};
      spl_pkg::OFS_RANGE: rd_mux = {28'h0, rng_r};
      spl_pkg::OFS_STAT: begin
        rd_mux[spl_pkg::ST_WIP] = !idle;
        rd_mux[spl_pkg::ST_PERR] = perr_r;
        rd_mux[spl_pkg::ST_GATE] = gate_r;
        rd_mux[spl_pkg::ST_PWMODE] = pwd_mode;
        rd_mux[spl_pkg::ST_MODE_LO +: 2] = mode_r;
      end
      spl_pkg::OFS_LOCKRD: begin
        rd_mux[7:0] = nv_r[sect_r] ? spl_pkg::LOCK_BYTE_OPEN :
                      spl_pkg::LOCK_BYTE_PROT;
        rd_mux[15:8] = vol_r[sect_r] ? spl_pkg::LOCK_BYTE_OPEN :
                       spl_pkg::LOCK_BYTE_PROT;
      end
      default: rd_mux = '0;
    endcase
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_range_all: assert property (rng_r[2:0] == 3'h7 |->
    sect_protected_o) else $error("full range guard left sector open");
  a_nv_denied: assert property (idle && cmd_go && !any_rst &&
    !gate_r && cmd == spl_pkg::OP_NV_ERASE |=> state_r == spl_pkg::SPL_FAIL
    && perr_r && $stable(nv_r)) else $error("nv erase ran with gate clear");
  a_persist_hold: assert property (!pwd_mode && !gate_r &&
    !hw_rst_i |=> !gate_r)
    else $error("gate set by command in persistent mode");
  a_gate_rise: assert property ($rose(gate_r) |->
    $past(hw_rst_i) || $past(unlock_ok))
    else $error("gate set without reset or unlock");
  a_gate_clear: assert property (cmd_go && idle && !any_rst &&
    cmd == spl_pkg::OP_GATE_CLR |=> !gate_r)
    else $error("gate clear command ignored");
  a_mode_frozen: assert property (mode_r != spl_pkg::MODE_NONE |=>
    $stable(mode_r)) else $error("guard mode changed after selection");
  a_vol_reset: assert property (any_rst |=> &vol_r)
    else $error("volatile locks not reopened by reset");
  a_bad_pwd: assert property (unlock_bad && !any_rst |=> perr_r &&
    write_in_progress_flag_o && !gate_r)
    else $error("bad password not reported");
  a_gap_block: assert property (gap_r != '0 && cmd_go && idle &&
    !any_rst && cmd == spl_pkg::OP_PWD_UNLOCK |=> idle && $stable(gate_r))
    else $error("unlock accepted inside gap");
  a_wip_hold: assert property (go_mode |=>
    write_in_progress_flag_o [*8])
    else $error("mode program not reported busy");

  c_unlock: cover property (unlock_ok);
  c_nv_prog: cover property (op_bus.done && op_r == spl_pkg::OP_NV_PROG);
  c_mode_pw: cover property ($rose(pwd_mode));
endmodule

// ===== tb/spl_host_model.sv
// apb host model standing in for the serial command controller
`timescale 1ns/1ps
module spl_host_model (
  input wire logic core_clk_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end
  // enter just after a rising edge; returns one edge after release
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    @(posedge core_clk_i);
    while (pready_i !== 1'b1) @(posedge core_clk_i);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines change, so a stale address can never pass
    paddr_o <= ~a;
    pwdata_o <= ~d;
    @(posedge core_clk_i);
  endtask
endmodule

// ===== tb/spl_top_tb_top.sv
// self-checking bench for the sector protection logic
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, x); end end
module spl_top_tb_top;
  logic core_clk_i;
  logic rst_i = 1'b1;
  logic hw_rst_i = 1'b0;
  logic sw_rst_i = 1'b0;
  logic [7:0] query_sect_i = 8'h00;
  wire psel, penable, pwrite, pready, pslverr, sect_prot, write_in_progress_flag, gate;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  int checks = 0;
  int fail_count = 0;
  logic [31:0] q;
  logic e;
  // short gap keeps the unlock throttle test brief
  spl_top #(.UNLOCK_GAP_CYC(60)) u_spl_top (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .hw_rst_i(hw_rst_i), .sw_rst_i(sw_rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .query_sect_i(query_sect_i),
    .sect_protected_o(sect_prot), .write_in_progress_flag_o(write_in_progress_flag),
    .lock_gate_bit_o(gate));
  spl_host_model u_spl_host_model (.core_clk_i(core_clk_i),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ****************************************************************
  // bus helpers
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_spl_host_model.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    u_spl_host_model.xfer(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
  endtask
  task automatic cmd(input logic [3:0] op);
    wr(spl_pkg::OFS_CMD, {28'h0, op});
  endtask
  task automatic sect_cmd(input logic [7:0] s, input logic [3:0] op,
    input logic [7:0] d);
    wr(spl_pkg::OFS_SECT, {24'h0, s});
    wr(spl_pkg::OFS_DATA, {24'h0, d});
    cmd(op);
  endtask
  task automatic lockrd(input logic [7:0] s, input logic [15:0] x);
    wr(spl_pkg::OFS_SECT, {24'h0, s});
    rd(spl_pkg::OFS_LOCKRD, {16'h0, x});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 1000) begin
      u_spl_host_model.xfer(1'b0, spl_pkg::OFS_STAT, 32'h0, q, e);
      n++;
    end
    `CHK(q[0], 1'b0)
  endtask
  task automatic chk_prot(input logic [7:0] s, input logic x);
    query_sect_i <= s;
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    `CHK(sect_prot, x)
  endtask
  task automatic rst_pulse(input bit hw);
    if (hw) hw_rst_i <= 1'b1;
    else sw_rst_i <= 1'b1;
    @(posedge core_clk_i);
    hw_rst_i <= 1'b0;
    sw_rst_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(spl_pkg::OFS_STAT, 32'h34);
    chk_prot(8'h00, 1'b0);
    chk_prot(8'hff, 1'b0);
    u_spl_host_model.xfer(1'b0, 8'h20, 32'h0, q, e);
    `CHK({e, q}, 33'h100000000)
    $display("test reset done");
  endtask
  task automatic t_vol;
    sect_cmd(8'h05, spl_pkg::OP_VOL_WRITE, 8'h00);
    lockrd(8'h05, 16'h00ff);
    chk_prot(8'h05, 1'b1);
    chk_prot(8'h06, 1'b0);
    sect_cmd(8'h05, spl_pkg::OP_VOL_WRITE, 8'hff);
    chk_prot(8'h05, 1'b0);
    $display("test volatile done");
  endtask
  task automatic t_nv;
    sect_cmd(8'h09, spl_pkg::OP_NV_PROG, 8'h00);
    rd(spl_pkg::OFS_STAT, 32'h35);
    `CHK(write_in_progress_flag, 1'b1)
    wait_idle();
    lockrd(8'h09, 16'hff00);
    chk_prot(8'h09, 1'b1);
    sect_cmd(8'h0a, spl_pkg::OP_NV_PROG, 8'h00);
    wait_idle();
    wr(spl_pkg::OFS_RANGE, 32'h9);
    chk_prot(8'h03, 1'b1);
    chk_prot(8'h04, 1'b0);
    wr(spl_pkg::OFS_RANGE, 32'h1);
    chk_prot(8'hfc, 1'b1);
    chk_prot(8'hfb, 1'b0);
    wr(spl_pkg::OFS_RANGE, 32'h7);
    chk_prot(8'h80, 1'b1);
    wr(spl_pkg::OFS_RANGE, 32'h0);
    cmd(spl_pkg::OP_NV_ERASE);
    wait_idle();
    lockrd(8'h09, 16'hffff);
    lockrd(8'h0a, 16'hffff);
    $display("test nonvolatile done");
  endtask
  task automatic t_gate;
    sect_cmd(8'h07, spl_pkg::OP_NV_PROG, 8'h00);
    wait_idle();
    cmd(spl_pkg::OP_GATE_CLR);
    rd(spl_pkg::OFS_STAT, 32'h30);
    sect_cmd(8'h08, spl_pkg::OP_NV_PROG, 8'h00);
    rd(spl_pkg::OFS_STAT, 32'h33);
    cmd(spl_pkg::OP_CLR_STAT);
    lockrd(8'h08, 16'hffff);
    cmd(spl_pkg::OP_NV_ERASE);
    rd(spl_pkg::OFS_STAT, 32'h33);
    cmd(spl_pkg::OP_CLR_STAT);
    lockrd(8'h07, 16'hff00);
    sect_cmd(8'h03, spl_pkg::OP_VOL_WRITE, 8'h00);
    lockrd(8'h03, 16'h00ff);
    cmd(spl_pkg::OP_PWD_UNLOCK);
    rd(spl_pkg::OFS_STAT, 32'h30);
    rst_pulse(1'b0);
    rd(spl_pkg::OFS_STAT, 32'h30);
    lockrd(8'h03, 16'hffff);
    rst_pulse(1'b1);
    rd(spl_pkg::OFS_STAT, 32'h34);
    cmd(spl_pkg::OP_NV_ERASE);
    wait_idle();
    $display("test gate done");
  endtask
  task automatic t_pwd;
    wr(spl_pkg::OFS_PWD_LO, 32'h9abcdef0);
    wr(spl_pkg::OFS_PWD_HI, 32'h12345678);
    cmd(spl_pkg::OP_PWD_PROG);
    wait_idle();
    sect_cmd(8'h00, spl_pkg::OP_MODE_PROG, 8'h00);
    rd(spl_pkg::OFS_STAT, 32'h37);
    cmd(spl_pkg::OP_CLR_STAT);
    sect_cmd(8'h00, spl_pkg::OP_MODE_PROG, 8'h02);
    rd(spl_pkg::OFS_STAT, 32'h35);
    wait_idle();
    rd(spl_pkg::OFS_STAT, 32'h1c);
    sect_cmd(8'h00, spl_pkg::OP_MODE_PROG, 8'h04);
    rd(spl_pkg::OFS_STAT, 32'h1f);
    cmd(spl_pkg::OP_CLR_STAT);
    rst_pulse(1'b1);
    rd(spl_pkg::OFS_STAT, 32'h18);
    wr(spl_pkg::OFS_PWD_LO, 32'h0);
    cmd(spl_pkg::OP_PWD_UNLOCK);
    rd(spl_pkg::OFS_STAT, 32'h1b);
    wr(spl_pkg::OFS_PWD_LO, 32'h9abcdef0);
    cmd(spl_pkg::OP_CLR_STAT);
    cmd(spl_pkg::OP_PWD_UNLOCK);
    rd(spl_pkg::OFS_STAT, 32'h18);
    repeat (70) @(posedge core_clk_i);
    cmd(spl_pkg::OP_PWD_UNLOCK);
    rd(spl_pkg::OFS_STAT, 32'h1c);
    cmd(spl_pkg::OP_GATE_CLR);
    rd(spl_pkg::OFS_STAT, 32'h18);
    `CHK(gate, 1'b0)
    rst_i <= 1'b1;
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    sect_cmd(8'h00, spl_pkg::OP_MODE_PROG, 8'h04);
    wait_idle();
    rd(spl_pkg::OFS_STAT, 32'h24);
    $display("test password done");
  endtask
  task automatic results;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset();
    t_vol();
    t_nv();
    t_gate();
    t_pwd();
    results();
  end
  // tests need well under 20000 cycles, so this only trips on a hang
  initial begin
    repeat (40000) @(posedge core_clk_i);
    fail_count++;
    results();
  end
endmodule
